// file: nvw_cfg.svh
// Offsets, bit positions, reset values and timing for the data EEPROM write control
`ifndef NVW_CFG_SVH
`define NVW_CFG_SVH
`define NVW_OFS_IRQ_EN2 12'hfa0
`define NVW_OFS_IRQ_FLAG2 12'hfa1
`define NVW_OFS_IRQ_PRIO2 12'hfa2
`define NVW_OFS_CONTROL 12'hfa6
`define NVW_OFS_KEY 12'hfa7
`define NVW_OFS_DATA 12'hfa8
`define NVW_OFS_ADDRESS 12'hfa9
`define NVW_OFS_CORE_IRQ 12'hff2
`define NVW_BIT_PGM 7
`define NVW_BIT_CFG 6
`define NVW_BIT_ERASE 4
`define NVW_BIT_ABORT 3
`define NVW_BIT_PERMIT 2
`define NVW_BIT_WR 1
`define NVW_BIT_RD 0
`define NVW_BIT_DONE 4
`define NVW_KEY_FIRST 8'h55
`define NVW_KEY_SECOND 8'haa
`define NVW_RST_BYTE 8'h00
`define NVW_RST_FIVE 5'h00
`define NVW_RST_PRIO 5'h1f
`define NVW_RST_CORE_HI 7'h00
`define NVW_CLK_KHZ 50000
`define NVW_PUT_MS 72
`define NVW_PUT_CYCLES (`NVW_PUT_MS * `NVW_CLK_KHZ)
`define NVW_WRITE_US 4000
`define NVW_WRITE_CYCLES (`NVW_WRITE_US * `NVW_CLK_KHZ / 1000)
`endif

// file: nvw_pkg.sv
// Types for the data EEPROM write control
package nvw_pkg;
    typedef enum logic [1:0] {
        NVW_LOCKED = 2'b00,
        NVW_KEY1 = 2'b01,
        NVW_ARMED = 2'b10
    } nvw_unlock_t;
endpackage

// file: nvw_ctrl.sv
// Data EEPROM byte write control with unlock sequence and SFR access
`timescale 1ns/1ns
`default_nettype none
`include "nvw_cfg.svh"
module nvw_ctrl
    import nvw_pkg::*;
#(
    parameter int unsigned PUT_CYCLES = `NVW_PUT_CYCLES,
    parameter int unsigned WRITE_CYCLES = `NVW_WRITE_CYCLES
) (
    // Clock and resets
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic MCLR_B,
    input wire logic WDT_RST,
    // SFR access from the core
    input wire logic [11:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WE,
    input wire logic SFR_RE,
    output logic [7:0] SFR_RDATA,
    // Interrupt request and priority of write done
    output logic WRITE_DONE_IRQ,
    output logic WRITE_DONE_HIGH_PRIO,
    // Code protect configuration
    input wire logic CODE_PROTECT_DATA,
    input wire logic CODE_PROTECT_PROG,
    // External programming access
    input wire logic [7:0] EXT_ADDR,
    input wire logic [7:0] EXT_WDATA,
    input wire logic EXT_WE,
    input wire logic EXT_RE,
    output logic [7:0] EXT_RDATA,
    output logic EXT_DENIED,
    // Status
    output logic WRITE_BUSY,
    output logic PUT_RUNNING
);
    logic [7:0] mem [0:255];
    logic mclr_s1_reg;
    logic mclr_s2_reg;
    logic pgm_reg;
    logic cfg_reg;
    logic erase_reg;
    logic abort_reg;
    logic permit_reg;
    logic wr_reg;
    logic rd_reg;
    logic [7:0] addr_reg;
    logic [7:0] data_reg;
    logic [4:0] flag_reg;
    logic [4:0] en_reg;
    logic [4:0] prio_reg;
    logic [7:0] core_irq_reg;
    logic [21:0] put_cnt_reg;
    logic put_run_reg;
    logic [21:0] wr_cnt_reg;
    logic [7:0] rdata_reg;
    logic [7:0] ext_rdata_reg;
    logic ext_denied_reg;
    nvw_unlock_t state_reg;
    nvw_unlock_t state_next;

    // MCLR is a pin; only the second stage is read
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mclr_s1_reg <= 1'b1;
            mclr_s2_reg <= 1'b1;
        end else begin
            mclr_s1_reg <= MCLR_B;
            mclr_s2_reg <= mclr_s1_reg;
        end
    end

    wire warm_rst = !mclr_s2_reg || WDT_RST;
    wire we_ctl = SFR_WE && SFR_ADDR == `NVW_OFS_CONTROL;
    wire we_key = SFR_WE && SFR_ADDR == `NVW_OFS_KEY;
    wire we_data = SFR_WE && SFR_ADDR == `NVW_OFS_DATA;
    wire we_addr = SFR_WE && SFR_ADDR == `NVW_OFS_ADDRESS;
    wire we_flag = SFR_WE && SFR_ADDR == `NVW_OFS_IRQ_FLAG2;
    wire we_en = SFR_WE && SFR_ADDR == `NVW_OFS_IRQ_EN2;
    wire we_prio = SFR_WE && SFR_ADDR == `NVW_OFS_IRQ_PRIO2;
    wire we_core = SFR_WE && SFR_ADDR == `NVW_OFS_CORE_IRQ;
    // Control, address and data frozen while a write runs
    wire ctl_ok = we_ctl && !wr_reg;
    wire new_pgm = SFR_WDATA[`NVW_BIT_PGM];
    wire new_cfg = SFR_WDATA[`NVW_BIT_CFG];
    wire data_space = !new_pgm && !new_cfg;
    // Old permit value is used, so permit and trigger in one write fail
    wire start_wr = ctl_ok && SFR_WDATA[`NVW_BIT_WR] && state_reg == NVW_ARMED
        && permit_reg && !put_run_reg && data_space;
    wire start_rd = ctl_ok && SFR_WDATA[`NVW_BIT_RD] && data_space;
    wire wr_done = wr_reg && wr_cnt_reg == 22'(WRITE_CYCLES - 1);
    wire ext_block = CODE_PROTECT_DATA || CODE_PROTECT_PROG;
    wire ext_wr_ok = EXT_WE && !ext_block && !wr_reg;

    // Any SFR write other than the next expected step drops the unlock
    always_comb begin
        state_next = state_reg;
        if (SFR_WE) begin
            state_next = NVW_LOCKED;
            if (we_key && SFR_WDATA == `NVW_KEY_FIRST && !wr_reg) begin
                state_next = NVW_KEY1;
            end else if (we_key && SFR_WDATA == `NVW_KEY_SECOND && state_reg == NVW_KEY1) begin
                state_next = NVW_ARMED;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= NVW_LOCKED;
        end else if (warm_rst) begin
            state_reg <= NVW_LOCKED;
        end else begin
            unique case (state_reg)
                NVW_LOCKED, NVW_KEY1, NVW_ARMED: state_reg <= state_next;
                default: state_reg <= NVW_LOCKED;
            endcase
        end
    end

    // Power-up timer: counts once after power-on release only
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            put_cnt_reg <= 22'h000000;
            put_run_reg <= 1'b1;
        end else if (put_run_reg) begin
            put_cnt_reg <= put_cnt_reg + 22'h000001;
            put_run_reg <= put_cnt_reg != 22'(PUT_CYCLES - 1);
        end
    end

    // Space selects and abort survive a warm reset for tracing
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pgm_reg <= 1'b0;
            cfg_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else if (warm_rst) begin
            abort_reg <= abort_reg || wr_reg;
        end else begin
            if (ctl_ok) begin
                pgm_reg <= new_pgm;
                cfg_reg <= new_cfg;
            end
            if (ctl_ok) begin
                abort_reg <= SFR_WDATA[`NVW_BIT_ABORT];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            erase_reg <= 1'b0;
            permit_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else if (warm_rst) begin
            erase_reg <= 1'b0;
            permit_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            if (ctl_ok) begin
                erase_reg <= SFR_WDATA[`NVW_BIT_ERASE];
                permit_reg <= SFR_WDATA[`NVW_BIT_PERMIT];
            end
            // Trigger bits are set only; software zeros are ignored
            if (start_wr) begin
                wr_reg <= 1'b1;
            end else if (wr_done) begin
                wr_reg <= 1'b0;
            end
            rd_reg <= start_rd;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_cnt_reg <= 22'h000000;
        end else if (warm_rst || !wr_reg) begin
            wr_cnt_reg <= 22'h000000;
        end else begin
            wr_cnt_reg <= wr_cnt_reg + 22'h000001;
        end
    end

    // Address and data; reset forces both to zero
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            addr_reg <= `NVW_RST_BYTE;
            data_reg <= `NVW_RST_BYTE;
        end else if (warm_rst) begin
            addr_reg <= `NVW_RST_BYTE;
            data_reg <= `NVW_RST_BYTE;
        end else begin
            if (we_addr && !wr_reg) begin
                addr_reg <= SFR_WDATA;
            end
            if (we_data && !wr_reg) begin
                data_reg <= SFR_WDATA;
            end else if (rd_reg) begin
                data_reg <= mem[addr_reg];
            end
        end
    end

    // Array is written at the end of a full write cycle or by an external write; an abort leaves it
    always_ff @(posedge SYS_CLK) begin
        if (wr_done && !warm_rst && RST_B) begin
            mem[addr_reg] <= data_reg;
        end else if (ext_wr_ok && !warm_rst && RST_B) begin
            mem[EXT_ADDR] <= EXT_WDATA;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flag_reg <= `NVW_RST_FIVE;
            en_reg <= `NVW_RST_FIVE;
            prio_reg <= `NVW_RST_PRIO;
            core_irq_reg <= `NVW_RST_BYTE;
        end else if (warm_rst) begin
            flag_reg <= `NVW_RST_FIVE;
            en_reg <= `NVW_RST_FIVE;
            prio_reg <= `NVW_RST_PRIO;
            core_irq_reg <= {`NVW_RST_CORE_HI, core_irq_reg[0]};
        end else begin
            if (we_flag) begin
                flag_reg <= SFR_WDATA[4:0];
            end
            if (wr_done) begin
                flag_reg[`NVW_BIT_DONE] <= 1'b1;
            end
            if (we_en) begin
                en_reg <= SFR_WDATA[4:0];
            end
            if (we_prio) begin
                prio_reg <= SFR_WDATA[4:0];
            end
            if (we_core) begin
                core_irq_reg <= SFR_WDATA;
            end
        end
    end

    wire [7:0] ctl_view = {pgm_reg, cfg_reg, 1'b0, erase_reg,
        abort_reg, permit_reg, wr_reg, rd_reg};
    // Key location is not storage and always reads zero
    wire [7:0] rd_mux =
        SFR_ADDR == `NVW_OFS_CONTROL ? ctl_view :
        SFR_ADDR == `NVW_OFS_DATA ? data_reg :
        SFR_ADDR == `NVW_OFS_ADDRESS ? addr_reg :
        SFR_ADDR == `NVW_OFS_IRQ_FLAG2 ? {3'h0, flag_reg} :
        SFR_ADDR == `NVW_OFS_IRQ_EN2 ? {3'h0, en_reg} :
        SFR_ADDR == `NVW_OFS_IRQ_PRIO2 ? {3'h0, prio_reg} :
        SFR_ADDR == `NVW_OFS_CORE_IRQ ? core_irq_reg : 8'h00;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= 8'h00;
            ext_rdata_reg <= 8'h00;
            ext_denied_reg <= 1'b0;
        end else begin
            if (SFR_RE) begin
                rdata_reg <= rd_mux;
            end
            // Protected reads return zero, never the array
            if (EXT_RE) begin
                ext_rdata_reg <= ext_block ? 8'h00 : mem[EXT_ADDR];
            end
            ext_denied_reg <= (EXT_RE || EXT_WE) && ext_block;
        end
    end

    assign SFR_RDATA = rdata_reg;
    assign EXT_RDATA = ext_rdata_reg;
    assign EXT_DENIED = ext_denied_reg;
    assign WRITE_DONE_IRQ = flag_reg[`NVW_BIT_DONE] && en_reg[`NVW_BIT_DONE];
    assign WRITE_DONE_HIGH_PRIO = prio_reg[`NVW_BIT_DONE];
    assign WRITE_BUSY = wr_reg;
    assign PUT_RUNNING = put_run_reg;
endmodule
`default_nettype wire

// file: nvw_ctrl_checker.sv
// Port-level assertions for the data EEPROM write control
`timescale 1ns/1ns
`default_nettype none
module nvw_ctrl_checker #(
    parameter int unsigned PUT_CYCLES = 20,
    parameter int unsigned WRITE_CYCLES = 8
) (
    // Clock, resets and SFR writes
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic WDT_RST,
    input wire logic MCLR_B,
    input wire logic [11:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WE,
    // Status and external access
    input wire logic WRITE_BUSY,
    input wire logic PUT_RUNNING,
    input wire logic WRITE_DONE_IRQ,
    input wire logic WRITE_DONE_HIGH_PRIO,
    input wire logic EXT_WE,
    input wire logic EXT_RE,
    input wire logic CODE_PROTECT_DATA,
    input wire logic CODE_PROTECT_PROG,
    input wire logic EXT_DENIED
);
    localparam int END_MAX = WRITE_CYCLES;
    wire ext_blk = (EXT_WE || EXT_RE) && (CODE_PROTECT_DATA || CODE_PROTECT_PROG);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    busy_start_a: assert property (
        $rose(WRITE_BUSY) |-> $past(SFR_WE && SFR_ADDR == 12'hfa6 && SFR_WDATA[1])
        && $past(SFR_WDATA[7:6]) == 2'b00) else $error("write began without trigger");
    put_block_a: assert property (
        $rose(WRITE_BUSY) |-> !$past(PUT_RUNNING)) else $error("write began in power-up");
    reset_state_a: assert property (
        $rose(RST_B) |-> WRITE_DONE_HIGH_PRIO && PUT_RUNNING) else $error("bad reset state");
    ext_deny_a: assert property (
        ext_blk |=> EXT_DENIED) else $error("protected access not denied");
    ext_allow_a: assert property (
        !ext_blk |=> !EXT_DENIED) else $error("denial without cause");
    busy_hold_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B || WDT_RST || !MCLR_B)
        $rose(WRITE_BUSY) |-> WRITE_BUSY[*8]) else $error("write ended early");
    busy_end_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B || WDT_RST || !MCLR_B)
        $rose(WRITE_BUSY) |-> ##[1:END_MAX] !WRITE_BUSY) else $error("write never ended");
    irq_keep_a: assert property (
        $fell(WRITE_DONE_IRQ) |-> $past(SFR_WE) || $past(WDT_RST) || !$past(MCLR_B, 3))
        else $error("flag self-cleared");
endmodule
`default_nettype wire

// file: nvw_cpu.sv
// CPU software model driving the SFR bus
`timescale 1ns/1ns
`default_nettype none
module nvw_cpu (
    // SFR bus
    input wire logic clk,
    output var logic [11:0] addr = 12'h000,
    output var logic [7:0] wdata = 8'h00,
    output var logic we = 1'b0,
    output var logic re = 1'b0,
    input wire logic [7:0] rdata
);
    // Idle cycles before each write, for a slow caller
    int slow = 0;
    // Control value of the trigger write, changed only for refused cases
    logic [7:0] fin = 8'h06;
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        repeat (slow) @(posedge clk);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        we = 1'b1;
        @(posedge clk);
        #1;
        we = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        re = 1'b1;
        @(posedge clk);
        #1;
        re = 1'b0;
        d = rdata;
    endtask
    // Interrupts off first, else a handler could split the unlock
    task automatic ee_write(input logic [7:0] a, d, pre, k2);
        wr(12'hff2, 8'h00);
        wr(12'hfa9, a);
        wr(12'hfa8, d);
        wr(12'hfa6, pre);
        wr(12'hfa7, 8'h55);
        wr(12'hfa7, k2);
        wr(12'hfa6, fin);
    endtask
    task automatic ee_read(input logic [7:0] a, output logic [7:0] d);
        wr(12'hfa9, a);
        wr(12'hfa6, 8'h01);
        rd(12'hfa8, d);
    endtask
endmodule
`default_nettype wire

// file: nvw_ctrl_tb.sv
// Self-checking bench for the data EEPROM write control
`timescale 1ns/1ns
`default_nettype none
module nvw_ctrl_tb;
    logic clk = 1'b0, rst_b = 1'b0, wdt_rst = 1'b0, cp_d = 1'b0, cp_p = 1'b0, x_we = 1'b0;
    logic mclr_b = 1'b1;
    logic x_re = 1'b0, s_we, s_re, irq, prio, denied, busy, put_run;
    logic [7:0] x_a = 8'h00, x_d = 8'h00, a, d, rb, s_wd, s_rd, x_rd;
    logic [11:0] s_a;
    logic [11:0] zero_regs [6] = '{12'hfa1, 12'hfa6, 12'hfa7, 12'hfa8, 12'hfa9, 12'hfa3};
    int seed, failures = 0, comparisons = 0, cycles = 0;
    nvw_ctrl #(.PUT_CYCLES(40), .WRITE_CYCLES(8)) u_nvw_ctrl (.SYS_CLK(clk), .RST_B(rst_b),
        .MCLR_B(mclr_b), .WDT_RST(wdt_rst), .SFR_ADDR(s_a), .SFR_WDATA(s_wd), .SFR_WE(s_we),
        .SFR_RE(s_re), .SFR_RDATA(s_rd), .WRITE_DONE_IRQ(irq), .WRITE_DONE_HIGH_PRIO(prio),
        .CODE_PROTECT_DATA(cp_d), .CODE_PROTECT_PROG(cp_p), .EXT_ADDR(x_a), .EXT_WDATA(x_d),
        .EXT_WE(x_we), .EXT_RE(x_re), .EXT_RDATA(x_rd), .EXT_DENIED(denied),
        .WRITE_BUSY(busy), .PUT_RUNNING(put_run));
    nvw_cpu u_nvw_cpu (.clk(clk), .addr(s_a), .wdata(s_wd), .we(s_we), .re(s_re), .rdata(s_rd));
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] exp_ctl(input logic permit, input logic abort);
        return {4'h0, abort, permit, 2'b00};
    endfunction
    task automatic ext_op(input logic we, input logic re, input logic [7:0] ad, input logic [7:0] dd);
        @(posedge clk);
        #1;
        {x_we, x_re, x_a, x_d} = {we, re, ad, dd};
        @(posedge clk);
        #1;
        {x_we, x_re} = 2'b00;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        seed = 79;
        repeat (8) @(posedge clk);
        #1;
        rst_b = 1'b1;
        u_nvw_cpu.rd(12'hfa2, rb);
        chk("priority", rb, 8'h1f);
        chk("priority out", {7'h0, prio}, 8'h01);
        foreach (zero_regs[k]) begin
            u_nvw_cpu.rd(zero_regs[k], rb);
            chk("reset value", rb, 8'h00);
        end
        u_nvw_cpu.ee_write(8'h10, 8'h5a, 8'h04, 8'haa);
        chk("busy in power-up", {7'h0, busy}, 8'h00);
        while (put_run === 1'b1) @(posedge clk);
        $display("power-up test done");
        u_nvw_cpu.wr(12'hfa0, 8'h10);
        for (int j = 0; j < 3; j++) begin
            u_nvw_cpu.fin = (j == 2) ? 8'h86 : 8'h06;
            u_nvw_cpu.ee_write(8'h20, 8'h77, j ? 8'h04 : 8'h00, (j == 1) ? 8'h55 : 8'haa);
            chk("busy bad unlock", {7'h0, busy}, 8'h00);
        end
        u_nvw_cpu.fin = 8'h06;
        cp_d = 1'b1;
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            d = 8'($random(seed));
            cp_p = i[0];
            u_nvw_cpu.slow = i;
            u_nvw_cpu.ee_write(a, d, 8'h04, 8'haa);
            u_nvw_cpu.slow = 0;
            chk("busy", {7'h0, busy}, 8'h01);
            u_nvw_cpu.wr(12'hfa9, ~a);
            u_nvw_cpu.wr(12'hfa6, 8'h00);
            while (busy === 1'b1) @(posedge clk);
            u_nvw_cpu.rd(12'hfa1, rb);
            chk("done flag", rb, 8'h10);
            chk("done irq", {7'h0, irq}, 8'h01);
            u_nvw_cpu.rd(12'hfa6, rb);
            chk("control", rb, exp_ctl(1'b1, 1'b0));
            u_nvw_cpu.rd(12'hfa9, rb);
            chk("address", rb, a);
            u_nvw_cpu.wr(12'hfa1, 8'h00);
            chk("irq cleared", {7'h0, irq}, 8'h00);
            u_nvw_cpu.ee_read(a, rb);
            chk("stored byte", rb, d);
        end
        $display("write test done");
        u_nvw_cpu.ee_write(8'h21, 8'h66, 8'h04, 8'haa);
        @(posedge clk);
        #1;
        wdt_rst = 1'b1;
        @(posedge clk);
        #1;
        wdt_rst = 1'b0;
        u_nvw_cpu.rd(12'hfa6, rb);
        chk("abort", rb, exp_ctl(1'b0, 1'b1));
        u_nvw_cpu.wr(12'hfa6, 8'h00);
        u_nvw_cpu.ee_write(8'h22, 8'h99, 8'h04, 8'haa);
        chk("busy before pin reset", {7'h0, busy}, 8'h01);
        @(posedge clk);
        #1;
        mclr_b = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        mclr_b = 1'b1;
        repeat (3) @(posedge clk);
        chk("busy after pin reset", {7'h0, busy}, 8'h00);
        u_nvw_cpu.rd(12'hfa6, rb);
        chk("pin abort", rb, exp_ctl(1'b0, 1'b1));
        {cp_d, cp_p} = 2'b00;
        ext_op(1'b1, 1'b0, 8'h33, 8'hc3);
        ext_op(1'b0, 1'b1, 8'h33, 8'h00);
        chk("ext read", x_rd, 8'hc3);
        cp_p = 1'b1;
        ext_op(1'b0, 1'b1, 8'h33, 8'h00);
        chk("ext blocked", x_rd, 8'h00);
        chk("ext denied", {7'h0, denied}, 8'h01);
        $display("abort and protect test done");
        end_of_test();
    end
endmodule
bind nvw_ctrl nvw_ctrl_checker #(.PUT_CYCLES(PUT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .SYS_CLK, .RST_B, .WDT_RST, .MCLR_B, .SFR_ADDR, .SFR_WDATA, .SFR_WE, .WRITE_BUSY, .PUT_RUNNING,
    .WRITE_DONE_IRQ, .WRITE_DONE_HIGH_PRIO, .EXT_WE, .EXT_RE, .CODE_PROTECT_DATA,
    .CODE_PROTECT_PROG, .EXT_DENIED);
`default_nettype wire
